/* File: erps_pkg.sv */
// Constants and carrier types for the E1 receive payload and signaling
// register bank. Assumes a 32-bit Wishbone word per 8-bit register.
package erps_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_TX_EN = 8'hCC;
    localparam logic [7:0] IDX_PA_STATE = 8'hCD;
    localparam logic [7:0] IDX_PA_CMD = 8'hCE;
    localparam logic [7:0] IDX_PA_BYTE = 8'hCF;
    localparam logic [7:0] IDX_PL_SETUP = 8'hD0;
    localparam logic [7:0] IDX_RX_EN = 8'hD1;
    localparam logic [7:0] IDX_SG_SETUP = 8'hD2;
    localparam logic [7:0] IDX_SA_STATE = 8'hD3;
    localparam logic [7:0] IDX_SA_CMD = 8'hD4;
    localparam logic [7:0] IDX_SA_BYTE = 8'hD5;
    localparam logic [7:0] IDX_COS0 = 8'hD6;
    localparam logic [7:0] IDX_COS3 = 8'hD9;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_ENABLE = 0;
    localparam int BIT_BUSY = 0;
    localparam int BIT_RNW = 7;
    localparam int BIT_SNAP = 7;
    localparam int BIT_GTRK = 6;
    localparam int BIT_FREEZE = 3;
    localparam int BIT_DEB = 2;
    localparam int BIT_SIG_CHANGE_IRQ_ENABLE = 1;
    localparam int BIT_SLOT_TRK = 4;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Indirect map bases inside the payload control space
    localparam logic [6:0] PL_TRUNK_BASE = 7'h20;
    localparam logic [6:0] PL_COND_BASE = 7'h40;
    localparam int PL_DEPTH = 96;
    localparam int SG_DEPTH = 32;
    localparam int NUM_COS = 30;

    // Cycles an indirect access keeps the busy flag up
    localparam int ACC_CYCLES_DEF = 2;

    typedef enum logic [2:0] {
        SUB_PER_SLOT = 3'h0,
        SUB_TRUNK = 3'h1,
        SUB_ALAW = 3'h2,
        SUB_MULAW = 3'h3
    } erps_slot_substitution_select_t;

    // Digital milliwatt sequences, one byte per frame
    localparam logic [7:0] ALAW_MW [8] = '{8'h34, 8'h21, 8'h21, 8'h34,
                                          8'hB4, 8'hA1, 8'hA1, 8'hB4};
    localparam logic [7:0] MULAW_MW [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E,
                                           8'h9E, 8'h8B, 8'h8B, 8'h9E};

    // One received timeslot with its frame number and ABCD bits
    typedef struct packed {
        logic [4:0] slot;
        logic [3:0] frame;
        logic [3:0] abcd;
        logic [7:0] data;
    } erps_slot_t;

endpackage : erps_pkg

/* File: erps_regs.sv */
// Register bank and receive datapath of one E1 payload/signaling link.
// Assumes a classic Wishbone master and a timeslot stream synchronous
// to clk_i; a stream word is valid for the single cycle pl_valid_i is 1.
//
// How it works
// - Transmit enable 0 stops transmit functions
// - Payload busy flag shows indirect access running
// - Command bit7 read, bits 6:0 address
// - Payload space 00-3F, 41-4F, 51-5F only
// - Write: data byte first, then command
// - Read: command, then data byte holds result
// - Snapshot holds first frame ABCD per multiframe
// - Global trunk enable forces conditioning code
// - Selector 000 per slot, 001 trunk code
// - Selector 010 A-law, 011 mu-law pattern
// - Receive enable 0 stops substitution, snapshot repeat and conditioning
// - Freeze holds stored ABCD values
// - Debounce needs two identical codewords
// - Interrupt while enabled and any flag set
// - Signaling space 01-0F, 11-1F only
// - Signaling buffer has own busy flag
// - Flag sets when slot signaling changes
// - Writing one clears flag, zero keeps
`timescale 1ns/1ps
`default_nettype none

module erps_regs #(
    parameter int ACC_CYCLES = erps_pkg::ACC_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pl_valid_i,
    input wire erps_pkg::erps_slot_t pl_i,
    input wire logic mf_sync_i,
    output logic pl_valid_o,
    output logic [7:0] pl_data_o,
    output logic [3:0] rx_signaling_out_o,
    output logic tx_payload_ctrl_en_o,
    output logic irq_o
);

    if (ACC_CYCLES < 1 || ACC_CYCLES > 255) begin : g_chk
        $error("ACC_CYCLES must lie in 1..255");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic pl_addr_ok(input logic [6:0] a);
        return (a <= 7'h3F) || (a >= 7'h41 && a <= 7'h4F)
            || (a >= 7'h51 && a <= 7'h5F);
    endfunction : pl_addr_ok

    function automatic logic sg_addr_ok(input logic [6:0] a);
        return (a != 7'h00) && (a != 7'h10) && (a <= 7'h1F);
    endfunction : sg_addr_ok

    // Slots 1..15 map to flags 0..14, slots 17..31 to flags 15..29
    function automatic logic [4:0] cos_idx(input logic [4:0] s);
        return (s < 5'h10) ? 5'(s - 5'h01) : 5'(s - 5'h02);
    endfunction : cos_idx

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [31:0] rd_next;
    logic [7:0] idx;
    logic wr;

    assign idx = wb_adr_i[9:2];
    // Writes land on the edge that the master samples ack
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
            rdat_reg <= rd_next;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic tx_en_reg;
    logic rx_en_reg;
    logic [7:0] pl_setup_reg;
    logic [7:0] sg_setup_reg;
    logic snap_on;
    logic gtrk;
    logic [2:0] gsub;

    assign snap_on = pl_setup_reg[erps_pkg::BIT_SNAP];
    assign gtrk = pl_setup_reg[erps_pkg::BIT_GTRK];
    assign gsub = pl_setup_reg[2:0];
    assign tx_payload_ctrl_en_o = tx_en_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_en_reg <= 1'b0;
            rx_en_reg <= 1'b0;
            pl_setup_reg <= erps_pkg::RST_BYTE;
            sg_setup_reg <= erps_pkg::RST_BYTE;
        end else if (wr) begin
            if (idx == erps_pkg::IDX_TX_EN) begin
                tx_en_reg <= wb_dat_i[erps_pkg::BIT_ENABLE];
            end else if (idx == erps_pkg::IDX_RX_EN) begin
                rx_en_reg <= wb_dat_i[erps_pkg::BIT_ENABLE];
            end else if (idx == erps_pkg::IDX_PL_SETUP) begin
                // Reserved bits 5:3 are not kept
                pl_setup_reg <= {wb_dat_i[7:6], 3'h0, wb_dat_i[2:0]};
            end else if (idx == erps_pkg::IDX_SG_SETUP) begin
                sg_setup_reg <= {4'h0, wb_dat_i[3:1], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Indirect access engines
    // ------------------------------------------------------------
    logic [7:0] pa_cmd_reg;
    logic [7:0] pa_byte_reg;
    logic pa_busy_reg;
    logic [7:0] pa_cnt_reg;
    logic pa_start;
    logic pa_done;
    logic [7:0] sa_cmd_reg;
    logic [7:0] sa_byte_reg;
    logic sa_busy_reg;
    logic [7:0] sa_cnt_reg;
    logic sa_start;
    logic sa_done;

    // A command written while busy is dropped entirely
    assign pa_start = wr && idx == erps_pkg::IDX_PA_CMD && !pa_busy_reg;
    assign sa_start = wr && idx == erps_pkg::IDX_SA_CMD && !sa_busy_reg;
    assign pa_done = pa_busy_reg && pa_cnt_reg == 8'h01;
    assign sa_done = sa_busy_reg && sa_cnt_reg == 8'h01;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_busy_reg <= 1'b0;
            pa_cnt_reg <= 8'h00;
        end else if (pa_start) begin
            pa_busy_reg <= 1'b1;
            pa_cnt_reg <= 8'(ACC_CYCLES);
        end else if (pa_busy_reg) begin
            pa_busy_reg <= !pa_done;
            pa_cnt_reg <= pa_cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sa_busy_reg <= 1'b0;
            sa_cnt_reg <= 8'h00;
        end else if (sa_start) begin
            sa_busy_reg <= 1'b1;
            sa_cnt_reg <= 8'(ACC_CYCLES);
        end else if (sa_busy_reg) begin
            sa_busy_reg <= !sa_done;
            sa_cnt_reg <= sa_cnt_reg - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Indirect memories
    // ------------------------------------------------------------
    logic [7:0] pl_mem [erps_pkg::PL_DEPTH];
    logic [3:0] sg_mem [erps_pkg::SG_DEPTH];
    logic [3:0] last_mem [erps_pkg::SG_DEPTH];
    logic [3:0] snap_mem [erps_pkg::SG_DEPTH];
    logic [6:0] pa_adr;
    logic [6:0] sa_adr;
    logic pa_rnw;
    logic sa_rnw;

    assign pa_adr = pa_cmd_reg[6:0];
    assign sa_adr = sa_cmd_reg[6:0];
    assign pa_rnw = pa_cmd_reg[erps_pkg::BIT_RNW];
    assign sa_rnw = sa_cmd_reg[erps_pkg::BIT_RNW];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_cmd_reg <= erps_pkg::RST_BYTE;
            pa_byte_reg <= erps_pkg::RST_BYTE;
        end else begin
            if (pa_start) begin
                pa_cmd_reg <= wb_dat_i[7:0];
            end
            if (pa_done && pa_rnw) begin
                // Holes in the map read back as zero
                pa_byte_reg <= pl_addr_ok(pa_adr) ? pl_mem[pa_adr]
                                                  : 8'h00;
            end else if (wr && idx == erps_pkg::IDX_PA_BYTE) begin
                pa_byte_reg <= wb_dat_i[7:0];
            end
        end
    end

    // Payload control contents are not cleared by reset
    always_ff @(posedge clk_i) begin
        if (pa_done && !pa_rnw && pl_addr_ok(pa_adr)) begin
            pl_mem[pa_adr] <= pa_byte_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sa_cmd_reg <= erps_pkg::RST_BYTE;
            sa_byte_reg <= erps_pkg::RST_BYTE;
        end else begin
            if (sa_start) begin
                sa_cmd_reg <= wb_dat_i[7:0];
            end
            if (sa_done && sa_rnw) begin
                sa_byte_reg <= sg_addr_ok(sa_adr)
                    ? {4'h0, sg_mem[sa_adr[4:0]]} : 8'h00;
            end else if (wr && idx == erps_pkg::IDX_SA_BYTE) begin
                sa_byte_reg <= wb_dat_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Signaling buffer update
    // ------------------------------------------------------------
    logic [4:0] slot;
    logic upd_cand;
    logic upd_en;
    logic sg_change;
    logic host_sg_wr;

    assign slot = pl_i.slot;
    assign upd_cand = pl_valid_i && slot != 5'h00 && slot != 5'h10;
    assign upd_en = upd_cand
        && !sg_setup_reg[erps_pkg::BIT_FREEZE]
        && (!sg_setup_reg[erps_pkg::BIT_DEB]
            || last_mem[slot] == pl_i.abcd);
    assign sg_change = upd_en && sg_mem[slot] != pl_i.abcd;
    assign host_sg_wr = sa_done && !sa_rnw && sg_addr_ok(sa_adr);

    always_ff @(posedge clk_i) begin
        if (upd_cand) begin
            last_mem[slot] <= pl_i.abcd;
        end
        // A received update wins over a host write to the same slot in the same cycle
        if (upd_en) begin
            sg_mem[slot] <= pl_i.abcd;
        end
        if (host_sg_wr && !(upd_en && slot == sa_adr[4:0])) begin
            sg_mem[sa_adr[4:0]] <= sa_byte_reg[3:0];
        end
    end

    // ------------------------------------------------------------
    // Change-of-signaling flags and interrupt
    // ------------------------------------------------------------
    logic [erps_pkg::NUM_COS-1:0] cos_reg;
    logic [erps_pkg::NUM_COS-1:0] cos_set;
    logic [31:0] cos_clr;
    logic [31:0] cos_wide;
    logic irq_reg;
    logic [1:0] cos_byte;

    assign cos_wide = {2'b00, cos_reg};
    // Lane in the flag bank; the 2-bit wrap keeps the select in range
    assign cos_byte = 2'(idx - erps_pkg::IDX_COS0);

    always_comb begin
        cos_set = '0;
        cos_clr = 32'h0000_0000;
        if (sg_change) begin
            cos_set[cos_idx(slot)] = 1'b1;
        end
        if (wr && idx >= erps_pkg::IDX_COS0 && idx <= erps_pkg::IDX_COS3) begin
            cos_clr[8*cos_byte +: 8] =
                wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cos_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            // Set beats clear so no change is lost
            cos_reg <= (cos_reg & ~cos_clr[erps_pkg::NUM_COS-1:0])
                | cos_set;
            irq_reg <= sg_setup_reg[erps_pkg::BIT_SIG_CHANGE_IRQ_ENABLE]
                && (|cos_reg);
        end
    end

    assign irq_o = irq_reg;

    // ------------------------------------------------------------
    // Receive payload substitution and signaling output
    // ------------------------------------------------------------
    logic [2:0] mw_ph_reg;
    logic pl_valid_reg;
    logic [7:0] pl_data_reg;
    logic [3:0] sig_out_reg;
    logic [2:0] sub_sel;
    logic [7:0] cond_byte;
    logic [7:0] sub_data;
    logic [3:0] sig_src;
    logic [3:0] sig_fin;

    assign cond_byte = pl_mem[7'(erps_pkg::PL_COND_BASE + {2'b00, slot})];

    always_comb begin
        sub_sel = (gsub == erps_pkg::SUB_PER_SLOT)
            ? pl_mem[{2'b00, slot}][7:5] : gsub;
        sub_data = pl_i.data;
        if (rx_en_reg) begin
            case (sub_sel)
                erps_pkg::SUB_TRUNK:
                    sub_data = pl_mem[7'(erps_pkg::PL_TRUNK_BASE
                        + {2'b00, slot})];
                erps_pkg::SUB_ALAW: sub_data = erps_pkg::ALAW_MW[mw_ph_reg];
                erps_pkg::SUB_MULAW: sub_data = erps_pkg::MULAW_MW[mw_ph_reg];
                default: sub_data = pl_i.data;
            endcase
        end
        // Frame 0 passes live bits; later frames repeat the latch
        sig_src = (rx_en_reg && snap_on && mf_sync_i && pl_i.frame != 4'h0)
            ? snap_mem[slot] : pl_i.abcd;
        sig_fin = sig_src;
        if (rx_en_reg && (gtrk || cond_byte[erps_pkg::BIT_SLOT_TRK])) begin
            sig_fin = cond_byte[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (pl_valid_i && pl_i.frame == 4'h0) begin
            snap_mem[slot] <= pl_i.abcd;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mw_ph_reg <= 3'h0;
            pl_valid_reg <= 1'b0;
            pl_data_reg <= 8'h00;
            sig_out_reg <= 4'h0;
        end else begin
            if (pl_valid_i && slot == 5'h1F) begin
                mw_ph_reg <= mw_ph_reg + 3'h1;
            end
            pl_valid_reg <= pl_valid_i;
            if (pl_valid_i) begin
                pl_data_reg <= sub_data;
                sig_out_reg <= sig_fin;
            end
        end
    end

    assign pl_valid_o = pl_valid_reg;
    assign pl_data_o = pl_data_reg;
    assign rx_signaling_out_o = sig_out_reg;

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_next = 32'h0000_0000;
        if (idx == erps_pkg::IDX_TX_EN) begin
            rd_next[0] = tx_en_reg;
        end else if (idx == erps_pkg::IDX_PA_STATE) begin
            rd_next[erps_pkg::BIT_BUSY] = pa_busy_reg;
        end else if (idx == erps_pkg::IDX_PA_CMD) begin
            rd_next[7:0] = pa_cmd_reg;
        end else if (idx == erps_pkg::IDX_PA_BYTE) begin
            rd_next[7:0] = pa_byte_reg;
        end else if (idx == erps_pkg::IDX_PL_SETUP) begin
            rd_next[7:0] = pl_setup_reg;
        end else if (idx == erps_pkg::IDX_RX_EN) begin
            rd_next[0] = rx_en_reg;
        end else if (idx == erps_pkg::IDX_SG_SETUP) begin
            rd_next[7:0] = sg_setup_reg;
        end else if (idx == erps_pkg::IDX_SA_STATE) begin
            rd_next[erps_pkg::BIT_BUSY] = sa_busy_reg;
        end else if (idx == erps_pkg::IDX_SA_CMD) begin
            rd_next[7:0] = sa_cmd_reg;
        end else if (idx == erps_pkg::IDX_SA_BYTE) begin
            rd_next[7:0] = sa_byte_reg;
        end else if (idx >= erps_pkg::IDX_COS0 && idx <= erps_pkg::IDX_COS3) begin
            rd_next[7:0] =
                cos_wide[8*cos_byte +: 8];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_busy_run;
        pa_busy_reg [*8];
    endsequence

    a_ack_single: assert property (ack_reg |=> !ack_reg)
        else $error("ack held longer than one cycle");
    a_busy_span: assert property (
        (ACC_CYCLES == 8 && pa_start) |=> s_busy_run ##1 !pa_busy_reg)
        else $error("payload busy span wrong");
    a_busy_load: assert property (
        pa_start |=> pa_busy_reg && pa_cnt_reg == 8'(ACC_CYCLES))
        else $error("payload busy not raised");
    a_sbusy_load: assert property (
        sa_start |=> sa_busy_reg && sa_cnt_reg == 8'(ACC_CYCLES))
        else $error("signaling busy not raised");
    a_txen_write: assert property (
        wr && idx == erps_pkg::IDX_TX_EN
        |=> tx_payload_ctrl_en_o == $past(wb_dat_i[0]))
        else $error("transmit enable not taken");
    a_irq_gate: assert property (
        !sg_setup_reg[erps_pkg::BIT_SIG_CHANGE_IRQ_ENABLE] |=> !irq_o)
        else $error("interrupt raised while disabled");
    a_cos_clear: assert property (
        wr && idx == erps_pkg::IDX_COS0 && wb_dat_i[0] && !cos_set[0]
        |=> !cos_reg[0])
        else $error("flag not cleared by one");
    a_freeze_hold: assert property (
        sg_setup_reg[erps_pkg::BIT_FREEZE] |-> !upd_en)
        else $error("buffer updated while frozen");
    a_deb_pair: assert property (
        upd_en && sg_setup_reg[erps_pkg::BIT_DEB]
        |-> last_mem[slot] == pl_i.abcd)
        else $error("update without two equal codewords");
    a_rx_off_pass: assert property (
        pl_valid_i && !rx_en_reg |=> pl_data_o == $past(pl_i.data))
        else $error("data altered while disabled");
    a_read_result: assert property (
        pa_done && pa_rnw && pl_addr_ok(pa_adr)
        |=> pa_byte_reg == pl_mem[$past(pa_adr)])
        else $error("indirect read result wrong");

endmodule : erps_regs

`default_nettype wire

/* File: test_e1_rx_payload_signaling_regs.sv */
// Self-checking bench for the E1 payload and signaling register bank.
// Assumes erps_pkg and erps_regs are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module test_e1_rx_payload_signaling_regs;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pl_valid_i, mf_sync_i;
    logic [9:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic wb_ack_o, pl_valid_o, tx_payload_ctrl_en_o, irq_o;
    logic [7:0] pl_data_o;
    logic [3:0] rx_signaling_out_o;
    erps_pkg::erps_slot_t pl_i;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h307728C4;

    // Long busy window so the flag can be seen over the bus
    erps_regs #(.ACC_CYCLES(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pl_valid_i(pl_valid_i),
        .pl_i(pl_i), .mf_sync_i(mf_sync_i), .pl_valid_o(pl_valid_o),
        .pl_data_o(pl_data_o), .rx_signaling_out_o(rx_signaling_out_o),
        .tx_payload_ctrl_en_o(tx_payload_ctrl_en_o), .irq_o(irq_o));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Slots 0 and 16 carry no signaling, so they are skipped
    function automatic logic [4:0] slot_of(input logic [31:0] r);
        logic [4:0] s;
        s = 5'(r % 30 + 1);
        if (s >= 5'h10)
            s = s + 5'h01;
        return s;
    endfunction : slot_of

    task automatic print_verdict();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    // Classic single cycle; entered and left just after a rising edge
    task automatic wb(input logic we, input logic [7:0] idx,
        input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        if (n >= 50) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d);
    endtask : wr

    task automatic chk(input logic [7:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        check(q, {24'h0, e});
    endtask : chk

    task automatic ind(input logic [7:0] cmd, input logic [7:0] v);
        int n;
        wr(cmd, v);
        chk(cmd - 8'h01, 8'h01);
        n = 0;
        do begin
            wb(1'b0, cmd - 8'h01, 8'h00);
            n++;
        end while (q !== 32'h0 && n < 20);
        check(q, 32'h0);
        if (q !== 32'h0)
            print_verdict();
    endtask : ind

    task automatic iwr(input logic [7:0] cmd, input logic [6:0] a,
        input logic [7:0] d);
        wr(cmd + 8'h01, d);
        ind(cmd, {1'b0, a});
    endtask : iwr

    task automatic ird(input logic [7:0] cmd, input logic [6:0] a,
        input logic [7:0] e);
        ind(cmd, {1'b1, a});
        chk(cmd + 8'h01, e);
    endtask : ird

    task automatic send(input logic [4:0] s, input logic [3:0] f,
        input logic [3:0] abcd, input logic [7:0] d);
        pl_valid_i <= 1'b1;
        pl_i <= {s, f, abcd, d};
        @(posedge clk_i);
        pl_valid_i <= 1'b0;
        @(posedge clk_i);
        check({31'h0, pl_valid_o}, 32'h1);
    endtask : send

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        logic [4:0] s;
        logic [6:0] a, fr;
        logic [7:0] d, c, fb;
        logic [3:0] v, w;
        logic [6:0] bad [3];
        int i;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, pl_valid_i, mf_sync_i} = 5'h00;
        wb_adr_i = 10'h000;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        pl_i = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 'hCC; i <= 'hD9; i++)
            chk(8'(i), 8'h00);
        wr(8'h10, 8'hFF);
        chk(8'h10, 8'h00);
        wb_sel_i <= 4'hE;
        wr(8'hCC, 8'h01);
        wb_sel_i <= 4'hF;
        check({31'h0, tx_payload_ctrl_en_o}, 32'h0);
        wr(8'hCC, 8'h01);
        check({31'h0, tx_payload_ctrl_en_o}, 32'h1);
        wr(8'hCC, 8'h00);
        check({31'h0, tx_payload_ctrl_en_o}, 32'h0);
        for (i = 0; i < 6; i++) begin
            a = 7'(rnd() % 94);
            if (a >= 7'h40)
                a = a + 7'h01;
            if (a >= 7'h50)
                a = a + 7'h01;
            if (i < 2)
                a = i ? 7'h5F : 7'h00;
            d = 8'(rnd());
            iwr(8'hCE, a, d);
            wr(8'hCF, ~d);
            ird(8'hCE, a, d);
        end
        bad = '{7'h40, 7'h50, 7'h60};
        for (i = 0; i < 3; i++) begin
            iwr(8'hCE, bad[i], 8'hA5);
            ird(8'hCE, bad[i], 8'h00);
            iwr(8'hD4, bad[i] - 7'h40, 8'h05);
            ird(8'hD4, bad[i] - 7'h40, 8'h00);
        end
        s = slot_of(rnd());
        c = 8'(rnd());
        d = ~c;
        iwr(8'hCE, 7'h20 + 7'(s), c);
        wr(8'hD1, 8'h01);
        wr(8'hD0, 8'h01);
        send(s, 4'h0, 4'h0, d);
        check({24'h0, pl_data_o}, {24'h0, c});
        wr(8'hD0, 8'h02);
        send(s, 4'h0, 4'h0, d);
        fb = erps_pkg::ALAW_MW[(s == 5'h1F) ? 1 : 0];
        check({24'h0, pl_data_o}, {24'h0, fb});
        wr(8'hD0, 8'h03);
        send(s, 4'h0, 4'h0, d);
        fb = erps_pkg::MULAW_MW[(s == 5'h1F) ? 2 : 0];
        check({24'h0, pl_data_o}, {24'h0, fb});
        wr(8'hD0, 8'h01);
        wr(8'hD1, 8'h00);
        send(s, 4'h0, 4'h0, d);
        check({24'h0, pl_data_o}, {24'h0, d});
        iwr(8'hCE, 7'h40 + 7'(s), {4'h0, c[3:0]});
        wr(8'hD1, 8'h01);
        wr(8'hD0, 8'h40);
        send(s, 4'h1, ~c[3:0], d);
        check({28'h0, rx_signaling_out_o}, {28'h0, c[3:0]});
        wr(8'hD0, 8'h00);
        wr(8'hD1, 8'h00);
        wr(8'hD2, 8'h02);
        v = 4'(rnd());
        send(s, 4'h0, v, 8'h00);
        for (i = 0; i < 4; i++)
            wr(8'hD6 + 8'(i), 8'hFF);
        send(s, 4'h0, ~v, 8'h00);
        fr = (s < 5'h10) ? 7'(s) - 7'h01 : 7'(s) - 7'h02;
        fb = 8'h01 << fr[2:0];
        chk(8'hD6 + 8'(fr[6:3]), fb);
        check({31'h0, irq_o}, 32'h1);
        ird(8'hD4, 7'(s), {4'h0, ~v});
        wr(8'hD6 + 8'(fr[6:3]), 8'h00);
        chk(8'hD6 + 8'(fr[6:3]), fb);
        wr(8'hD2, 8'h00);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        wr(8'hD6 + 8'(fr[6:3]), fb);
        chk(8'hD6 + 8'(fr[6:3]), 8'h00);
        wr(8'hD2, 8'h08);
        send(s, 4'h0, v, 8'h00);
        ird(8'hD4, 7'(s), {4'h0, ~v});
        wr(8'hD2, 8'h04);
        w = v ^ 4'h5;
        send(s, 4'h0, w, 8'h00);
        ird(8'hD4, 7'(s), {4'h0, ~v});
        send(s, 4'h0, w, 8'h00);
        ird(8'hD4, 7'(s), {4'h0, w});
        wr(8'hD2, 8'h00);
        wr(8'hD1, 8'h01);
        wr(8'hD0, 8'h80);
        mf_sync_i <= 1'b1;
        send(s, 4'h0, c[7:4], 8'h00);
        send(s, 4'h5, ~c[7:4], 8'h00);
        check({28'h0, rx_signaling_out_o}, {28'h0, c[7:4]});
        print_verdict();
    end
endmodule : test_e1_rx_payload_signaling_regs

`default_nettype wire
